/* hdl/microcore_branch_call_decode.sv */
// Branch, call and counter load execution for one microcore.
// Assumes fetch presents the word at PC the same cycle; AHB-Lite slave.
//
// Added by the designer: the AHB-Lite register port.
`timescale 1ns/1ps

// Summary of operation
// RQ1: Far status jump taken loads PC from selected jump register.
// RQ2: Status bit select field is a direct bit index 0 to 15.
// RQ3: Tested status bit comes from one of the four status registers, chosen by core control.
// RQ4: Sense 0 matches a zero bit, sense 1 matches a one bit.
// RQ5: Relative status jump taken loads PC with PC plus offset.
// RQ6: Relative offsets are 5-bit two's complement, -16 to 15.
// RQ7: Far call always goes to address in selected jump register.
// RQ8: Relative call goes to current address plus signed offset.
// RQ9: Both calls copy current PC into the return address register.
// RQ10: Far status jump encoding 001111, sense, select, reg, 0101.
// RQ11: Relative status jump encoding 001100, sense, select, offset.
// RQ12: Far call encoding 001110011011, register bit, then 101.
// RQ13: Relative call encoding 00101111001 then offset.
// RQ14: Counter load writes ALU value to chosen end count, applies shortcuts.
// RQ15: Clear flag 0 keeps count, 1 zeroes and restarts the counter.
// RQ16: Shortcut action 00 keep, 01 off, 10 on, 11 invert.
// RQ17: Shortcut outputs come from the shortcut definition mapping.
// RQ18: End count select 00 to 11 picks first to fourth register.
// RQ19: Jump registers are 16 bits, loaded from a 10-bit immediate.
// RQ20: Untaken status jump steps PC by one, return address unchanged.
// RQ21: Relative call is always taken.
module microcore_branch_call_decode
  import branch_decode_pkg::*;
(
  input  wire logic                 CLK_SYS,
  input  wire logic                 RESET_N,
  input  wire logic                 INSTR_VALID,
  input  wire logic [WORD_W-1:0]    INSTR,
  output logic      [CODE_AW-1:0]   PC,
  output logic      [CODE_AW-1:0]   RETURN_ADDR,
  output logic      [2:0]           ALU_SEL,
  input  wire logic [WORD_W-1:0]    ALU_DATA,
  output logic      [NUM_OUTS-1:0]  OUT_STATE,
  output logic      [NUM_COUNT-1:0] COUNT_DONE,
  input  wire logic                 HSEL,
  input  wire logic [31:0]          HADDR,
  input  wire logic [1:0]           HTRANS,
  input  wire logic                 HWRITE,
  input  wire logic [2:0]           HSIZE,
  input  wire logic [31:0]          HWDATA,
  input  wire logic                 HREADY,
  output logic      [31:0]          HRDATA,
  output logic                      HREADYOUT,
  output logic                      HRESP
);

  logic [CODE_AW-1:0]  pc_reg;
  logic [CODE_AW-1:0]  pc_next;
  logic [CODE_AW-1:0]  aux_reg;
  logic [CODE_AW-1:0]  aux_next;
  logic [WORD_W-1:0]   jump_a_reg;
  logic [WORD_W-1:0]   jump_b_reg;
  logic [WORD_W-1:0]   status_reg [NUM_COUNT];
  core_control_t       control_reg;
  logic [WORD_W-1:0]   eoc_reg [NUM_COUNT];
  logic [WORD_W-1:0]   cnt_reg [NUM_COUNT];
  logic [NUM_OUTS-1:0] out_reg;
  logic [NUM_OUTS-1:0] out_next;
  instr_kind_t         kind;
  count_load_t         load_f;
  logic                status_bit;
  logic                cond_met;
  logic [CODE_AW-1:0]  rel_target;
  logic [CODE_AW-1:0]  far_target;
  logic                wr_pend_reg;
  logic [11:0]         wr_idx_reg;
  logic [31:0]         rd_data_next;
  logic                addr_phase;
  logic [11:0]         bus_idx;
  logic                bus_hit_space;

  // Instruction classification
  always_comb begin
    if (INSTR[15:10] == OPC_JSRF_HI && INSTR[3:0] == OPC_JSRF_LO) begin
      kind = K_JSRF; // RQ10
    end else if (INSTR[15:10] == OPC_JSRR_HI) begin
      kind = K_JSRR; // RQ11
    end else if (INSTR[15:4] == OPC_JTSF_HI && INSTR[2:0] == OPC_JTSF_LO) begin
      kind = K_JTSF; // RQ12
    end else if (INSTR[15:5] == OPC_JTSR_HI) begin
      kind = K_JTSR; // RQ13
    end else if (INSTR[15:13] == OPC_CNTLD_HI
                 && INSTR[2:0] == OPC_CNTLD_LO) begin
      kind = K_CNTLD;
    end else if (INSTR[15:12] == OPC_LDJRA && INSTR[1:0] == OPC_LDJR_LO) begin
      kind = K_LDJA;
    end else if (INSTR[15:12] == OPC_LDJRB && INSTR[1:0] == OPC_LDJR_LO) begin
      kind = K_LDJB;
    end else begin
      kind = K_NONE;
    end
  end

  // Operand fields and targets
  assign load_f     = count_load_t'(INSTR[12:3]);
  assign ALU_SEL    = load_f.alu_select;
  assign status_bit = status_reg[control_reg.status_source][INSTR[8:5]]; // RQ2 RQ3
  assign cond_met   = (status_bit == INSTR[9]); // RQ4
  assign rel_target = pc_reg + {{(CODE_AW-5){INSTR[4]}}, INSTR[4:0]}; // RQ6
  assign far_target = ((kind == K_JSRF) ? INSTR[4] : INSTR[3])
                      ? jump_b_reg[CODE_AW-1:0] : jump_a_reg[CODE_AW-1:0];

  // Next program counter and return address
  always_comb begin
    pc_next  = pc_reg;
    aux_next = aux_reg;
    if (INSTR_VALID) begin
      pc_next = pc_reg + 10'h001; // RQ20
      case (kind)
        K_JSRF: begin
          if (cond_met) begin
            pc_next = far_target; // RQ1
          end
        end
        K_JSRR: begin
          if (cond_met) begin
            pc_next = rel_target; // RQ5
          end
        end
        K_JTSF: begin
          pc_next  = far_target; // RQ7
          aux_next = pc_reg; // RQ9
        end
        K_JTSR: begin
          pc_next  = rel_target; // RQ8 RQ21
          aux_next = pc_reg; // RQ9
        end
        default: begin
          pc_next = pc_reg + 10'h001;
        end
      endcase
    end
  end

  // Program counter and return address registers
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      pc_reg  <= PC_RESET;
      aux_reg <= PC_RESET;
    end else begin
      pc_reg  <= pc_next;
      aux_reg <= aux_next;
    end
  end

  // Jump registers, upper bits cleared on load
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      jump_a_reg <= STATUS_RESET;
      jump_b_reg <= STATUS_RESET;
    end else if (INSTR_VALID && kind == K_LDJA) begin
      jump_a_reg <= {6'h00, INSTR[11:2]}; // RQ19
    end else if (INSTR_VALID && kind == K_LDJB) begin
      jump_b_reg <= {6'h00, INSTR[11:2]}; // RQ19
    end
  end

  // End count registers and counters, one per entry
  for (genvar i = 0; i < NUM_COUNT; i++) begin : g_count
    logic load_here;
    assign load_here = INSTR_VALID && kind == K_CNTLD
                       && load_f.eoc_select == 2'(i); // RQ18
    always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
        eoc_reg[i] <= STATUS_RESET;
      end else if (load_here) begin
        eoc_reg[i] <= ALU_DATA; // RQ14
      end
    end
    // Counter wraps at its end count; clear restarts from zero
    always_ff @(posedge CLK_SYS) begin
      if (!RESET_N) begin
        cnt_reg[i] <= STATUS_RESET;
      end else if (load_here && load_f.clear) begin
        cnt_reg[i] <= STATUS_RESET; // RQ15
      end else if (cnt_reg[i] == eoc_reg[i]) begin
        cnt_reg[i] <= STATUS_RESET;
      end else begin
        cnt_reg[i] <= cnt_reg[i] + 16'h0001; // RQ15
      end
    end
    assign COUNT_DONE[i] = (cnt_reg[i] == eoc_reg[i]);
  end

  // Shortcut action on one output level
  function automatic logic apply_action(input logic cur,
                                        input logic [1:0] act);
    logic res;
    res = cur;
    case (act)
      SC_OFF:    res = 1'b0;
      SC_ON:     res = 1'b1;
      SC_TOGGLE: res = ~cur;
      default:   res = cur;
    endcase
    return res; // RQ16
  endfunction

  // Output levels; second shortcut applied after the first
  for (genvar j = 0; j < NUM_OUTS; j++) begin : g_out
    logic mid;
    assign mid = (control_reg.shortcut_a_map == 3'(j))
                 ? apply_action(out_reg[j], load_f.action_a) // RQ17
                 : out_reg[j];
    assign out_next[j] = (control_reg.shortcut_b_map == 3'(j))
                         ? apply_action(mid, load_f.action_b) // RQ17
                         : mid;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      out_reg <= '0;
    end else if (INSTR_VALID && kind == K_CNTLD) begin
      out_reg <= out_next; // RQ14
    end
  end

  // Bus address phase decode
  assign addr_phase    = HSEL && HTRANS[1] && HREADY;
  assign bus_idx       = HADDR[13:2];
  assign bus_hit_space = (HADDR[31:14] == 18'h00000);

  // Read data captured in the address phase
  always_comb begin
    rd_data_next = 32'h0000_0000;
    if (!bus_hit_space) begin
      rd_data_next = 32'h0000_0000;
    end else if (bus_idx == IDX_STATUS_A_FIRST) begin
      rd_data_next = {16'h0000, status_reg[0]};
    end else if (bus_idx == IDX_STATUS_B_FIRST) begin
      rd_data_next = {16'h0000, status_reg[1]};
    end else if (bus_idx == IDX_STATUS_A_SECOND) begin
      rd_data_next = {16'h0000, status_reg[2]};
    end else if (bus_idx == IDX_STATUS_B_SECOND) begin
      rd_data_next = {16'h0000, status_reg[3]};
    end else if (bus_idx == IDX_CORE_CONTROL) begin
      rd_data_next = {24'h000000, control_reg};
    end else if (bus_idx == IDX_CORE_STATE) begin
      rd_data_next = {6'h00, aux_reg, 6'h00, pc_reg};
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      HRDATA <= 32'h0000_0000;
    end else if (addr_phase && !HWRITE) begin
      HRDATA <= rd_data_next;
    end
  end

  // Pending write remembered for the data phase
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 12'h000;
    end else begin
      wr_pend_reg <= addr_phase && HWRITE && bus_hit_space;
      wr_idx_reg  <= bus_idx;
    end
  end

  // Software written registers
  always_ff @(posedge CLK_SYS) begin
    if (!RESET_N) begin
      for (int k = 0; k < NUM_COUNT; k++) begin
        status_reg[k] <= STATUS_RESET;
      end
      control_reg <= core_control_t'(CONTROL_RESET);
    end else if (wr_pend_reg) begin
      if (wr_idx_reg == IDX_STATUS_A_FIRST) begin
        status_reg[0] <= HWDATA[15:0];
      end else if (wr_idx_reg == IDX_STATUS_B_FIRST) begin
        status_reg[1] <= HWDATA[15:0];
      end else if (wr_idx_reg == IDX_STATUS_A_SECOND) begin
        status_reg[2] <= HWDATA[15:0];
      end else if (wr_idx_reg == IDX_STATUS_B_SECOND) begin
        status_reg[3] <= HWDATA[15:0];
      end else if (wr_idx_reg == IDX_CORE_CONTROL) begin
        control_reg <= core_control_t'(HWDATA[7:0]);
      end
    end
  end

  // Outputs
  assign PC          = pc_reg;
  assign RETURN_ADDR = aux_reg;
  assign OUT_STATE   = out_reg;
  assign HREADYOUT   = 1'b1;
  assign HRESP       = 1'b0;

  // Checks
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);

  sequence far_call_issue;
    INSTR_VALID && INSTR[15:4] == OPC_JTSF_HI && INSTR[2:0] == OPC_JTSF_LO;
  endsequence

  sequence rel_call_issue;
    INSTR_VALID && INSTR[15:5] == OPC_JTSR_HI;
  endsequence

  far_jump_a: assert property ( // RQ1
    INSTR_VALID && INSTR[15:10] == 6'h0F && INSTR[3:0] == 4'h5
    && cond_met |=> pc_reg == (($past(INSTR[4]) ? jump_b_reg
                               : jump_a_reg) & 16'h03FF))
    else $error("far status jump missed target");

  status_test_a: assert property ( // RQ4
    INSTR_VALID && INSTR[15:10] == OPC_JSRR_HI
    && (status_reg[control_reg.status_source][INSTR[8:5]] != INSTR[9])
    |=> pc_reg == $past(pc_reg) + 10'h001 && $stable(aux_reg))
    else $error("untaken status jump changed flow");

  rel_jump_a: assert property ( // RQ5
    INSTR_VALID && INSTR[15:10] == OPC_JSRR_HI && cond_met
    |=> $signed(pc_reg - $past(pc_reg)) == $signed($past(INSTR[4:0])))
    else $error("relative jump offset wrong");

  far_call_a: assert property ( // RQ7
    far_call_issue |=> aux_reg == $past(pc_reg)
    && pc_reg == ($past(INSTR[3]) ? jump_b_reg[CODE_AW-1:0]
                                  : jump_a_reg[CODE_AW-1:0]))
    else $error("far call wrong target or return");

  rel_call_a: assert property ( // RQ9
    rel_call_issue |=> aux_reg == $past(pc_reg)
    && $signed(pc_reg - aux_reg) == $signed($past(INSTR[4:0])))
    else $error("relative call wrong");

  eoc_load_a: assert property ( // RQ14
    INSTR_VALID && kind == K_CNTLD |=>
    eoc_reg[$past(INSTR[7:6])] == $past(ALU_DATA))
    else $error("end count not loaded");

  count_clear_a: assert property ( // RQ15
    INSTR_VALID && kind == K_CNTLD && INSTR[12] |=>
    cnt_reg[$past(INSTR[7:6])] == 16'h0000)
    else $error("counter not cleared");

  shortcut_on_a: assert property ( // RQ16
    INSTR_VALID && kind == K_CNTLD && INSTR[11:10] == SC_ON
    && control_reg.shortcut_b_map != control_reg.shortcut_a_map
    |=> out_reg[$past(control_reg.shortcut_a_map)])
    else $error("shortcut on not applied");

  jump_load_a: assert property ( // RQ19
    INSTR_VALID && INSTR[15:12] == OPC_LDJRA && INSTR[1:0] == 2'h0
    |=> jump_a_reg == {6'h00, $past(INSTR[11:2])})
    else $error("jump register load wrong");

  untaken_far_a: assert property ( // RQ20
    INSTR_VALID && kind == K_JSRF && !cond_met
    |=> pc_reg == $past(pc_reg) + 10'h001 && $stable(aux_reg))
    else $error("untaken far jump changed flow");

  shortcut_off_a: assert property ( // RQ16
    INSTR_VALID && kind == K_CNTLD && INSTR[11:10] == SC_OFF
    && control_reg.shortcut_b_map != control_reg.shortcut_a_map
    |=> !out_reg[$past(control_reg.shortcut_a_map)])
    else $error("shortcut off not applied");

  shortcut_flip_a: assert property ( // RQ16
    INSTR_VALID && kind == K_CNTLD && INSTR[9:8] == SC_TOGGLE
    && control_reg.shortcut_b_map != control_reg.shortcut_a_map
    |=> out_reg[$past(control_reg.shortcut_b_map)]
        != $past(out_reg[control_reg.shortcut_b_map]))
    else $error("shortcut invert not applied");

  count_keep_a: assert property ( // RQ15
    INSTR_VALID && kind == K_CNTLD && !INSTR[12]
    && cnt_reg[INSTR[7:6]] != eoc_reg[INSTR[7:6]]
    |=> cnt_reg[$past(INSTR[7:6])] == $past(cnt_reg[INSTR[7:6]]) + 16'h0001)
    else $error("counter not kept on load");

endmodule

/* hdl/branch_decode_pkg.sv */
// Constants, types and register map for the branch and call decoder.
// Assumes one core clock and a 16-bit instruction word from code fetch.
package branch_decode_pkg;

  // Widths
  localparam int CODE_AW   = 10;
  localparam int WORD_W    = 16;
  localparam int NUM_COUNT = 4;
  localparam int NUM_OUTS  = 8;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_STATUS_A_FIRST  = 12'h101;
  localparam logic [11:0] IDX_STATUS_B_FIRST  = 12'h102;
  localparam logic [11:0] IDX_STATUS_A_SECOND = 12'h121;
  localparam logic [11:0] IDX_STATUS_B_SECOND = 12'h122;
  localparam logic [11:0] IDX_CORE_CONTROL    = 12'h140;
  localparam logic [11:0] IDX_CORE_STATE      = 12'h141;

  // Reset values
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [7:0]  CONTROL_RESET = 8'h00;
  localparam logic [9:0]  PC_RESET      = 10'h000;

  // Opcode patterns
  localparam logic [5:0]  OPC_JSRF_HI = 6'h0F;   // 001111
  localparam logic [3:0]  OPC_JSRF_LO = 4'h5;    // 0101
  localparam logic [5:0]  OPC_JSRR_HI = 6'h0C;   // 001100
  localparam logic [11:0] OPC_JTSF_HI = 12'h39B; // 001110011011
  localparam logic [2:0]  OPC_JTSF_LO = 3'h5;    // 101
  localparam logic [10:0] OPC_JTSR_HI = 11'h179; // 00101111001
  localparam logic [2:0]  OPC_CNTLD_HI = 3'h5;   // 101
  localparam logic [2:0]  OPC_CNTLD_LO = 3'h4;   // 100
  localparam logic [3:0]  OPC_LDJRA   = 4'h8;    // 1000
  localparam logic [3:0]  OPC_LDJRB   = 4'h9;    // 1001
  localparam logic [1:0]  OPC_LDJR_LO = 2'h0;

  // Output shortcut actions
  localparam logic [1:0] SC_KEEP   = 2'h0;
  localparam logic [1:0] SC_OFF    = 2'h1;
  localparam logic [1:0] SC_ON     = 2'h2;
  localparam logic [1:0] SC_TOGGLE = 2'h3;

  // Decoded instruction kind
  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_JSRF = 3'b001,
    K_JSRR = 3'b010,
    K_JTSF = 3'b011,
    K_JTSR = 3'b100,
    K_CNTLD = 3'b101,
    K_LDJA = 3'b110,
    K_LDJB = 3'b111
  } instr_kind_t;

  // Core control register layout
  typedef struct packed {
    logic [2:0] shortcut_b_map;
    logic [2:0] shortcut_a_map;
    logic [1:0] status_source;
  } core_control_t;

  // Counter load fields
  typedef struct packed {
    logic       clear;
    logic [1:0] action_a;
    logic [1:0] action_b;
    logic [1:0] eoc_select;
    logic [2:0] alu_select;
  } count_load_t;

endpackage

/* verif/microcore_branch_call_decode_test.sv */
// Self-checking bench for the branch, call and counter load decoder.
// Assumes one core clock; bench acts as code fetch and AHB-Lite master.
`timescale 1ns/1ps
module microcore_branch_call_decode_test
  import branch_decode_pkg::*;
;
  logic                 CLK_SYS;
  logic                 RESET_N;
  logic                 INSTR_VALID;
  logic [WORD_W-1:0]    INSTR;
  logic [WORD_W-1:0]    ALU_DATA;
  logic [CODE_AW-1:0]   PC;
  logic [CODE_AW-1:0]   RETURN_ADDR;
  logic [2:0]           ALU_SEL;
  logic [NUM_OUTS-1:0]  OUT_STATE;
  logic [NUM_COUNT-1:0] COUNT_DONE;
  logic                 HSEL;
  logic                 HWRITE;
  logic                 HREADY;
  logic                 HREADYOUT;
  logic                 HRESP;
  logic [31:0]          HADDR;
  logic [31:0]          HWDATA;
  logic [31:0]          HRDATA;
  logic [1:0]           HTRANS;
  logic [2:0]           HSIZE;
  int                   errors;
  int                   comparisons;
  int                   cycles;
  logic [15:0]          stat [4];
  logic [9:0]           jr [2];
  logic [9:0]           pc;
  logic [9:0]           ret;
  logic [7:0]           outs;
  logic [31:0]          rd;
  logic [1:0]           s;
  logic [1:0]           a;
  logic [1:0]           bb;
  logic [2:0]           ma;
  logic [2:0]           mb;
  logic [2:0]           al;
  logic [4:0]           o;
  logic                 j;
  logic                 met;
  localparam logic [11:0] SIDX [4] = '{IDX_STATUS_A_FIRST, IDX_STATUS_B_FIRST,
    IDX_STATUS_A_SECOND, IDX_STATUS_B_SECOND};

  microcore_branch_call_decode uut (
    .CLK_SYS(CLK_SYS), .RESET_N(RESET_N), .INSTR_VALID(INSTR_VALID),
    .INSTR(INSTR), .PC(PC), .RETURN_ADDR(RETURN_ADDR), .ALU_SEL(ALU_SEL),
    .ALU_DATA(ALU_DATA), .OUT_STATE(OUT_STATE), .COUNT_DONE(COUNT_DONE),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
    .HREADYOUT(HREADYOUT), .HRESP(HRESP));

  // Single slave, so its ready is the bus ready
  assign HREADY = HREADYOUT;

  // Core clock
  initial CLK_SYS = 1'b0;
  always #5 CLK_SYS = ~CLK_SYS;

  // Watchdog against a hung handshake
  always @(posedge CLK_SYS) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      test_done();
    end
  end

  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // One single-word transfer; read data taken at the data phase edge
  task automatic bus(logic wr, logic [11:0] idx, logic [31:0] wd,
                     output logic [31:0] rdat);
    @(posedge CLK_SYS);
    HSEL <= 1'b1;
    HTRANS <= 2'h2;
    HADDR <= {18'h0, idx, 2'h0};
    HWRITE <= wr;
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    HSEL <= 1'b0;
    HTRANS <= 2'h0;
    HWDATA <= wd;
    do @(posedge CLK_SYS); while (HREADY !== 1'b1);
    rdat = HRDATA;
    check("hresp", HRESP, 32'h0);
  endtask

  // Present one word for exactly one executing edge
  task automatic exec(logic [15:0] w, logic [15:0] alu);
    @(posedge CLK_SYS);
    INSTR <= w;
    ALU_DATA <= alu;
    INSTR_VALID <= 1'b1;
    @(posedge CLK_SYS);
    INSTR_VALID <= 1'b0;
    #1;
  endtask

  function automatic logic [9:0] rel(logic [9:0] p, logic [4:0] off);
    return p + {{5{off[4]}}, off};
  endfunction

  function automatic logic sc(logic cur, logic [1:0] act);
    case (act)
      2'h0: return cur;
      2'h1: return 1'b0;
      2'h2: return 1'b1;
      default: return ~cur;
    endcase
  endfunction

  // Main sequence
  initial begin
    RESET_N = 1'b0;
    INSTR_VALID = 1'b0;
    INSTR = 16'h0000;
    ALU_DATA = 16'h0000;
    HSEL = 1'b0;
    HADDR = 32'h0;
    HTRANS = 2'h0;
    HWRITE = 1'b0;
    HSIZE = 3'h2;
    HWDATA = 32'h0;
    errors = 0;
    comparisons = 0;
    cycles = 0;
    pc = 10'h000;
    ret = 10'h000;
    outs = 8'h00;
    void'($urandom(21));
    repeat (20) @(posedge CLK_SYS);
    RESET_N <= 1'b1;
    #1;
    check("pc", PC, 32'h0);
    check("ret", RETURN_ADDR, 32'h0);
    check("outs", OUT_STATE, 32'h0);
    check("done", COUNT_DONE, 32'hF);
    repeat (3) begin
      @(posedge CLK_SYS);
      INSTR <= 16'($urandom);
    end
    #1 check("pc_idle", PC, 32'h0);
    $display("reset test finished");
    // Status registers read, write and an unmapped place
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, SIDX[i], 32'h0, rd);
      check("stat_rst", rd, 32'h0);
      stat[i] = 16'($urandom);
      bus(1'b1, SIDX[i], {16'hA5A5, stat[i]}, rd);
      bus(1'b0, SIDX[i], 32'h0, rd);
      check("stat_rw", rd, {16'h0, stat[i]});
    end
    bus(1'b1, 12'h0FF, 32'hFFFF_FFFF, rd);
    bus(1'b0, 12'h0FF, 32'h0, rd);
    check("unmapped", rd, 32'h0);
    $display("register test finished");
    // Status jumps over every bit, both senses, both kinds
    jr[0] = 10'($urandom);
    jr[1] = 10'($urandom);
    exec({4'h8, jr[0], 2'h0}, 16'h0);
    exec({4'h9, jr[1], 2'h0}, 16'h0);
    pc = pc + 10'd2;
    for (int i = 0; i < 64; i++) begin
      s = 2'($urandom);
      j = 1'($urandom);
      o = (i == 37) ? 5'h10 : (i == 38) ? 5'h0F : 5'($urandom);
      stat[s] = 16'($urandom);
      bus(1'b1, SIDX[s], {16'h0, stat[s]}, rd);
      bus(1'b1, IDX_CORE_CONTROL, {30'h0, s}, rd);
      met = (stat[s][i[3:0]] == i[4]);
      if (i < 32) begin
        exec({6'h0F, i[4], i[3:0], j, 4'h5}, 16'h0);
        pc = met ? jr[j] : pc + 10'd1;
      end else begin
        exec({6'h0C, i[4], i[3:0], o}, 16'h0);
        pc = met ? rel(pc, o) : pc + 10'd1;
      end
      check("pc_jump", PC, pc);
      check("ret_jump", RETURN_ADDR, ret);
    end
    $display("status jump test finished");
    // Far and relative calls, offset extremes included
    for (int i = 0; i < 16; i++) begin
      j = i[1];
      o = (i == 1) ? 5'h10 : (i == 3) ? 5'h0F : 5'($urandom);
      ret = pc;
      if (i[0]) begin
        exec({11'h179, o}, 16'h0);
        pc = rel(pc, o);
      end else begin
        exec({12'h39B, j, 3'h5}, 16'h0);
        pc = jr[j];
      end
      check("pc_call", PC, pc);
      check("ret_call", RETURN_ADDR, ret);
      bus(1'b0, IDX_CORE_STATE, 32'h0, rd);
      check("state_rd", rd, {6'h0, ret, 6'h0, pc});
    end
    $display("call test finished");
    // Counter loads with every pair of shortcut actions
    for (int i = 0; i < 32; i++) begin
      ma = 3'($urandom);
      mb = (i < 4) ? ma : 3'($urandom);
      al = 3'($urandom);
      bus(1'b1, IDX_CORE_CONTROL, {24'h0, mb, ma, 2'h0}, rd);
      bus(1'b0, IDX_CORE_CONTROL, 32'h0, rd);
      check("ctrl_rd", rd, {24'h0, mb, ma, 2'h0});
      a = i[1:0];
      bb = i[3:2];
      exec({3'h5, 1'b0, a, bb, 2'($urandom), al, 3'h4}, 16'($urandom));
      outs[ma] = sc(outs[ma], a);
      outs[mb] = sc(outs[mb], bb);
      pc = pc + 10'd1;
      check("outs", OUT_STATE, outs);
      check("alu_sel", ALU_SEL, al);
      check("pc_load", PC, pc);
    end
    $display("shortcut test finished");
    // Clear and end count on each of the four counters
    for (int i = 0; i < 4; i++) begin
      exec({3'h5, 1'b1, 4'h0, 2'(i), 3'h0, 3'h4}, 16'h0005);
      pc = pc + 10'd1;
      check("done_load", COUNT_DONE[i], 32'h0);
      repeat (4) @(posedge CLK_SYS);
      #1 check("done_early", COUNT_DONE[i], 32'h0);
      @(posedge CLK_SYS);
      #1 check("done_hit", COUNT_DONE[i], 32'h1);
      // Reload without clear: count runs on from its wrap
      exec({3'h5, 1'b0, 4'h0, 2'(i), 3'h0, 3'h4}, 16'h0007);
      pc = pc + 10'h001;
      repeat (5) @(posedge CLK_SYS);
      #1 check("done_keep", COUNT_DONE[i], 32'h0);
      @(posedge CLK_SYS);
      #1 check("done_kept", COUNT_DONE[i], 32'h1);
    end
    check("pc_end", PC, pc);
    $display("counter test finished");
    test_done();
  end
endmodule
